// *** dac_trig_defines.svh ***
// register offsets, field positions and reset values of the trigger control block
`ifndef DAC_TRIG_DEFINES_SVH
`define DAC_TRIG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_OUTPUT_ENABLE_MASK 5'h00
`define OFS_DAC_A              5'h02
`define OFS_DAC_B              5'h03
`define OFS_DAC_C              5'h04
`define OFS_DAC_D              5'h06
`define OFS_DAC_E              5'h07
`define OFS_DAC_F              5'h08
`define OFS_LAST_DAC_SELECT    5'h09
`define OFS_BOOST              5'h10
`define OFS_TRIG_CFG           5'h11
`define OFS_PM_TRIG            5'h1C
`define OFS_LAST_REG           5'h1F

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define TCFG_SEL_BIT           4
`define TCFG_EDGE_BIT          1
`define TCFG_MASK_BIT          0
`define TCFG_WRITE_MASK        8'h13
`define BOOST_FIXED_BIT        4
`define BOOST_FIXED_ONES       8'h10
`define PM_ACTIVE              2'h0
`define PM_STARTUP             2'h1
`define PM_LOW_POWER           2'h2
`define PM_RESERVED            2'h3
`define SSE_BIT                6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_OUTPUT_ENABLE_MASK 7'h40
`define RST_TRIG_CFG           8'h13
`define RST_BOOST              8'h1F
`define RST_PM                 2'h0

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define CMD_LAST_BIT           4'hC
`define DATA_LAST_BIT          4'h8
`define CMD_REG_WRITE          3'h2
`define CMD_EXT_WRITE          4'h0

`endif

// *** dac_trig_pkg.sv ***
// types of the trigger control block
package dac_trig_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ARM,
    ST_CMD,
    ST_ADDR,
    ST_DATA
  } link_e;

  typedef struct packed
  {
    link_e            st;
    logic [12:0]      sh;
    logic [3:0]       cnt;
    logic [4:0]       addr;
    logic             ext;
    logic [3:0]       left;
    logic             sclk_m;
    logic             sclk_s;
    logic             sclk_d;
    logic             sda_m;
    logic             sda_s;
    logic             sda_d;
    logic             trg_m;
    logic             trg_s;
    logic             trg_d;
    logic [6:0]       oe_mask;
    logic [7:0]       boost;
    logic [7:0]       tcfg;
    logic [2:0]       tmask;
    logic [1:0]       pmode;
    logic [2:0]       last_sel;
    logic [5:0][7:0]  shadow;
    logic [5:0][7:0]  active;
  } ctrl_s;

endpackage

// *** dac_update_trigger_ctrl.sv ***
// serial write slave with shadow to active transfer of six output levels
//
// Behaviour
// [RULE1] bus trigger selected: dac writes land in shadows, copied only on a trigger
// [RULE2] several writes before a trigger: the last complete value is applied
// [RULE3] pin trigger selected: writes load shadows, outputs load on active pin edge
// [RULE4] trigger config bit 1 picks the pin edge, 0 falling, 1 rising by default
// [RULE5] trigger config bit 0 set masks the pin, set by default
// [RULE6] trigger config bit 4 picks source, 0 pin, 1 bus trigger by default
// [RULE7] bus source and mask 0: writing dac c updates a, b, c together only
// [RULE8] bus source and mask 1: writing dac f updates d, e, f together only
// [RULE9] bus source and mask 2 with a selected last dac: writing it updates all six
// [RULE10] writing 1 to any software trigger bit copies shadows to outputs
// [RULE11] a set trigger mask bit passes data straight on; masks reset to 0
// [RULE12] a software trigger acts exactly like an active pin edge
// [RULE13] power field decodes active, startup, low power; code 3 changes nothing
// [RULE14] master sends start, slave address, a one, seven bits, parity, park
// [RULE15] the seven short frame bits store into the output enable mask
// [RULE16] the enable mask is also written by single and extended writes
// [RULE17] boost level bit 4 always reads and acts as one
// [RULE18] software trigger bits are one-shot strobes and never stay set
`timescale 1ns/1ps
`include "dac_trig_defines.svh"

module dac_update_trigger_ctrl #(
  parameter logic [3:0] slave_id = 4'hA  // arbitrary value
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // serial bus pins
  input  wire logic             sclk,
  input  wire logic             sdata,
  // external trigger pin
  input  wire logic             trig_pin,
  // output levels and enables, a to f
  output      logic [5:0][7:0]  dac_level,
  output      logic [5:0]       out_enable,
  // power and boost
  output      logic             spread_spectrum_enable,
  output      logic [7:0]       boost_output_level,
  output      logic             power_state_msb,
  output      logic             power_state_lsb,
  output      logic             boost_enable,
  output      logic             low_power
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dac_trig_pkg::ctrl_s r;
  dac_trig_pkg::ctrl_s nx;
  logic        sclk_fall;
  logic        clk_low;
  logic        sda_rise;
  logic        sda_fall;
  logic [12:0] cur;
  logic        par13;
  logic        par9;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        dac_wr;
  logic [2:0]  dac_idx;
  logic        sw_trig;
  logic        bus_sel;
  logic        pin_edge;
  logic        copy_abc;
  logic        copy_def;
  logic        copy_all;

  // ----------------------------------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------------------------------
  assign sclk_fall = r.sclk_d & ~r.sclk_s;
  assign clk_low   = ~r.sclk_s & ~r.sclk_d;
  assign sda_rise  = r.sda_s & ~r.sda_d;
  assign sda_fall  = ~r.sda_s & r.sda_d;
  assign cur       = {r.sh[11:0], r.sda_s};
  assign par13     = ^cur;
  assign par9      = ^cur[8:0];
  assign bus_sel   = r.tcfg[`TCFG_SEL_BIT];                                 // [RULE3]
  assign pin_edge  = ~bus_sel & ~r.tcfg[`TCFG_MASK_BIT] &                  // [RULE5]
                     (r.tcfg[`TCFG_EDGE_BIT] ? (r.trg_s & ~r.trg_d)        // [RULE4]
                                             : (~r.trg_s & r.trg_d));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nx       = r;
    wr_en    = 1'b0;
    wr_addr  = 5'h00;
    wr_data  = 8'h00;
    dac_wr   = 1'b0;
    dac_idx  = 3'h0;
    sw_trig  = 1'b0;
    copy_abc = 1'b0;
    copy_def = 1'b0;
    copy_all = 1'b0;
    nx.sclk_m = sclk;
    nx.sclk_s = r.sclk_m;
    nx.sclk_d = r.sclk_s;
    nx.sda_m  = sdata;
    nx.sda_s  = r.sda_m;
    nx.sda_d  = r.sda_s;
    nx.trg_m  = trig_pin;
    nx.trg_s  = r.trg_m;
    nx.trg_d  = r.trg_s;
    // frame receiver, bits taken on falling clock edges
    unique case (r.st)
      dac_trig_pkg::ST_IDLE:
      begin
        if (clk_low && sda_rise)
          nx.st = dac_trig_pkg::ST_ARM;
      end
      dac_trig_pkg::ST_ARM:
      begin
        if (!clk_low)
          nx.st = dac_trig_pkg::ST_IDLE;
        else if (sda_fall)
        begin
          nx.st  = dac_trig_pkg::ST_CMD;
          nx.cnt = 4'h0;
        end
      end
      dac_trig_pkg::ST_CMD:
      begin
        if (sclk_fall)
        begin
          nx.sh  = cur;
          nx.cnt = r.cnt + 4'h1;
          if (r.cnt == `CMD_LAST_BIT)
          begin
            nx.cnt = 4'h0;
            nx.st  = dac_trig_pkg::ST_IDLE;
            if (par13 && cur[12:9] == slave_id)
            begin
              if (cur[8])                                                  // [RULE14]
              begin
                wr_en   = 1'b1;                                            // [RULE15]
                wr_addr = `OFS_OUTPUT_ENABLE_MASK;
                wr_data = {1'b0, cur[7:1]};
              end
              else if (cur[8:6] == `CMD_REG_WRITE)
              begin
                nx.addr = cur[5:1];
                nx.ext  = 1'b0;
                nx.st   = dac_trig_pkg::ST_DATA;
              end
              else if (cur[8:5] == `CMD_EXT_WRITE)
              begin
                nx.left = cur[4:1];
                nx.st   = dac_trig_pkg::ST_ADDR;
              end
            end
          end
        end
      end
      dac_trig_pkg::ST_ADDR:
      begin
        if (sclk_fall)
        begin
          nx.sh  = cur;
          nx.cnt = r.cnt + 4'h1;
          if (r.cnt == `DATA_LAST_BIT)
          begin
            nx.cnt  = 4'h0;
            nx.addr = cur[5:1];
            nx.ext  = 1'b1;
            nx.st   = (par9 && cur[8:6] == 3'h0) ? dac_trig_pkg::ST_DATA
                                                 : dac_trig_pkg::ST_IDLE;
          end
        end
      end
      dac_trig_pkg::ST_DATA:
      begin
        if (sclk_fall)
        begin
          nx.sh  = cur;
          nx.cnt = r.cnt + 4'h1;
          if (r.cnt == `DATA_LAST_BIT)
          begin
            nx.cnt = 4'h0;
            nx.st  = dac_trig_pkg::ST_IDLE;
            if (par9)
            begin
              wr_en   = 1'b1;                                              // [RULE2]
              wr_addr = r.addr;
              wr_data = cur[8:1];
              if (r.ext && r.left != 4'h0 && r.addr != `OFS_LAST_REG)
              begin
                nx.left = r.left - 4'h1;
                nx.addr = r.addr + 5'h01;
                nx.st   = dac_trig_pkg::ST_DATA;
              end
            end
          end
        end
      end
    endcase
    // register writes
    if (wr_en)
    begin
      case (wr_addr)
        `OFS_OUTPUT_ENABLE_MASK: nx.oe_mask = wr_data[6:0];                // [RULE16]
        `OFS_BOOST:              nx.boost = wr_data | `BOOST_FIXED_ONES;   // [RULE17]
        `OFS_TRIG_CFG:           nx.tcfg = wr_data & `TCFG_WRITE_MASK;     // [RULE6]
        `OFS_LAST_DAC_SELECT:    nx.last_sel = wr_data[2:0];
        `OFS_PM_TRIG:
        begin
          nx.tmask = wr_data[5:3];
          if (wr_data[7:6] != `PM_RESERVED)                                // [RULE13]
            nx.pmode = wr_data[7:6];
          sw_trig = |wr_data[2:0];                                         // [RULE18]
        end
        `OFS_DAC_A: begin dac_wr = 1'b1; dac_idx = 3'h0; end
        `OFS_DAC_B: begin dac_wr = 1'b1; dac_idx = 3'h1; end
        `OFS_DAC_C: begin dac_wr = 1'b1; dac_idx = 3'h2; end
        `OFS_DAC_D: begin dac_wr = 1'b1; dac_idx = 3'h3; end
        `OFS_DAC_E: begin dac_wr = 1'b1; dac_idx = 3'h4; end
        `OFS_DAC_F: begin dac_wr = 1'b1; dac_idx = 3'h5; end
        default: ;
      endcase
    end
    // shadow load and transfer to the active levels
    if (dac_wr)
      nx.shadow[dac_idx] = wr_data;                                        // [RULE1]
    copy_abc = bus_sel & r.tmask[0] & dac_wr & (dac_idx == 3'h2);          // [RULE7]
    copy_def = bus_sel & r.tmask[1] & dac_wr & (dac_idx == 3'h5);          // [RULE8]
    copy_all = pin_edge | sw_trig |                                        // [RULE12]
               (bus_sel & r.tmask[2] & dac_wr &                            // [RULE9]
                (r.last_sel == dac_idx + 3'h1));
    for (int i = 0; i < 6; i++)
    begin
      if (copy_all || (copy_abc && i < 3) || (copy_def && i >= 3))         // [RULE11]
        nx.active[i] = nx.shadow[i];                                       // [RULE10]
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r         <= '0;
      r.oe_mask <= `RST_OUTPUT_ENABLE_MASK;
      r.tcfg    <= `RST_TRIG_CFG;
      r.boost   <= `RST_BOOST;
      r.pmode   <= `RST_PM;
    end
    else
      r <= nx;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dac_level              = r.active;
  assign out_enable             = {r.oe_mask[4], r.oe_mask[5], r.oe_mask[0],
                                   r.oe_mask[1], r.oe_mask[2], r.oe_mask[3]}
                                  & {6{r.pmode == `PM_ACTIVE}};            // [RULE13]
  assign spread_spectrum_enable = r.oe_mask[`SSE_BIT];
  assign boost_output_level     = r.boost;
  assign power_state_msb        = r.pmode[1];
  assign power_state_lsb        = r.pmode[0];
  assign boost_enable           = (r.pmode == `PM_ACTIVE) | (r.pmode == `PM_STARTUP);
  assign low_power              = (r.pmode == `PM_LOW_POWER);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence reg0_end_s;
    r.st == dac_trig_pkg::ST_CMD && sclk_fall && r.cnt == `CMD_LAST_BIT &&
    par13 && cur[12:9] == slave_id && cur[8];
  endsequence

  sequence pin_rise_s;
    !bus_sel && !r.tcfg[`TCFG_MASK_BIT] && r.tcfg[`TCFG_EDGE_BIT] && r.trg_s && !r.trg_d;
  endsequence

  sequence pin_fall_s;
    !bus_sel && !r.tcfg[`TCFG_MASK_BIT] && !r.tcfg[`TCFG_EDGE_BIT] && !r.trg_s && r.trg_d;
  endsequence

  shadow_hold_a: assert property ( // [RULE1]
    (bus_sel && dac_wr && r.tmask == 3'h0) |=> r.active == $past(r.active))
    else $error("dac write reached outputs without a trigger");

  latest_value_a: assert property ( // [RULE2]
    dac_wr |=> r.shadow[$past(dac_idx)] == $past(wr_data))
    else $error("shadow does not hold the last written value");

  pin_shadow_a: assert property ( // [RULE3]
    (!bus_sel && dac_wr && !pin_edge) |=> r.active == $past(r.active))
    else $error("pin mode write reached outputs without an edge");

  pin_rise_a: assert property ( // [RULE4]
    pin_rise_s |=> r.active == r.shadow)
    else $error("rising pin edge did not transfer shadows");

  pin_fall_a: assert property ( // [RULE3]
    pin_fall_s |=> r.active == r.shadow)
    else $error("falling pin edge did not transfer shadows");

  pin_mask_a: assert property ( // [RULE5]
    (r.tcfg[`TCFG_MASK_BIT] && !sw_trig && !dac_wr) |=> r.active == $past(r.active))
    else $error("masked pin changed the outputs");

  group_abc_a: assert property ( // [RULE7]
    (bus_sel && r.tmask[0] && !r.tmask[2] && dac_wr && dac_idx == 3'h2)
    |=> (r.active[2:0] == r.shadow[2:0]) && (r.active[5:3] == $past(r.active[5:3])))
    else $error("dac c write did not update group a b c alone");

  group_def_a: assert property ( // [RULE8]
    (bus_sel && r.tmask[1] && !r.tmask[2] && dac_wr && dac_idx == 3'h5)
    |=> (r.active[5:3] == r.shadow[5:3]) && (r.active[2:0] == $past(r.active[2:0])))
    else $error("dac f write did not update group d e f alone");

  last_dac_a: assert property ( // [RULE9]
    (bus_sel && r.tmask[2] && dac_wr && r.last_sel == dac_idx + 3'h1)
    |=> r.active == r.shadow)
    else $error("last dac write did not update all outputs");

  sw_copy_a: assert property ( // [RULE10]
    sw_trig |=> r.active == r.shadow)
    else $error("software trigger did not transfer shadows");

  pm_hold_a: assert property ( // [RULE13]
    (wr_en && wr_addr == `OFS_PM_TRIG && wr_data[7:6] == `PM_RESERVED)
    |=> r.pmode == $past(r.pmode))
    else $error("reserved power code changed the power state");

  boost_fixed_a: assert property ( // [RULE17]
    (wr_en && wr_addr == `OFS_BOOST)
    |=> r.boost[`BOOST_FIXED_BIT] && r.boost[3:0] == $past(wr_data[3:0]))
    else $error("boost bit 4 not forced to one");

  reg0_store_a: assert property ( // [RULE15]
    reg0_end_s |=> r.oe_mask == $past(cur[7:1]))
    else $error("short frame not stored in the enable mask");

endmodule

// *** rffe_master_model.sv ***
// serial bus master model sending write sequences to the trigger control block
`timescale 1ns/1ps

module rffe_master_model #(
  parameter logic [3:0] slave_id = 4'hA  // arbitrary value
) (
  // clock
  input  wire logic clock,
  // serial bus pins
  output      logic sclk,
  output      logic sdata
);
  int unsigned half    = 4;
  logic        bad_par = 1'b0;
  logic        bits[$];

  initial
  begin
    sclk  = 1'b0;
    sdata = 1'b0;
  end

  // one bit: data moves while the clock is high, the slave samples on the fall
  task automatic pulse(input logic b);
    @(posedge clock) sclk <= 1'b1;
    @(posedge clock) sdata <= b;
    repeat (half - 1) @(posedge clock);
    sclk <= 1'b0;
    repeat (half - 1) @(posedge clock);
  endtask

  task automatic add_cmd(input logic [11:0] c, input logic flip);
    for (int i = 11; i >= 0; i--) bits.push_back(c[i]);
    bits.push_back(~^c ^ flip);
  endtask

  task automatic add_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bits.push_back(b[i]);
    bits.push_back(~^b);
  endtask

  // start condition, frames, then park; the clock stands low between sequences
  task automatic send();
    @(posedge clock) sdata <= 1'b1;
    repeat (2) @(posedge clock);
    sdata <= 1'b0;
    repeat (2) @(posedge clock);
    while (bits.size() > 0) pulse(bits.pop_front());
    pulse(1'b0);
    bad_par = 1'b0;
  endtask

  task automatic reg0_write(input logic [6:0] d);
    add_cmd({slave_id, 1'b1, d}, bad_par);
    send();
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    add_cmd({slave_id, 3'h2, a}, bad_par);
    add_byte(d);
    send();
  endtask

  task automatic ext_write(input logic [4:0] a, input logic [7:0] d0, input logic [7:0] d1);
    add_cmd({slave_id, 8'h01}, bad_par);
    add_byte({3'h0, a});
    add_byte(d0);
    add_byte(d1);
    send();
  endtask
endmodule

// *** tb.sv ***
// self-checking bench of the trigger control block
`timescale 1ns/1ps
`include "dac_trig_defines.svh"

module tb;
  localparam logic [3:0] sid = 4'h5;  // arbitrary value
  localparam logic [7:0] pcfg [4] = '{8'hE2, 8'h0C, 8'h03, 8'h12};
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic             trig_pin = 1'b0;
  logic             sclk;
  logic             sdata;
  logic [5:0][7:0]  dac_level;
  logic [5:0]       out_enable;
  logic             spread_spectrum_enable;
  logic [7:0]       boost_output_level;
  logic             power_state_msb;
  logic             power_state_lsb;
  logic             boost_enable;
  logic             low_power;
  logic [3:0]       pw_seen;
  logic [5:0][7:0]  sh_x = 48'h0;
  logic [5:0][7:0]  act_x = 48'h0;
  logic [6:0]       oe_x = 7'h40;
  logic [7:0]       cfg_x = 8'h13;
  logic [7:0]       boost_x = 8'h1F;
  logic [2:0]       msk_x = 3'h0;
  logic [2:0]       last_x = 3'h0;
  logic [1:0]       pm_x = 2'h0;
  logic [7:0]       lfsr_r = 8'h25;
  logic [7:0]       v;
  int               error_cnt = 0;
  int               cmp_count = 0;
  int               cycles = 0;

  assign pw_seen = {power_state_msb, power_state_lsb, boost_enable, low_power};

  initial forever #12.5 clock = ~clock;

  dac_update_trigger_ctrl #(.slave_id(sid)) uut (
    .clock(clock), .rst(rst), .sclk(sclk), .sdata(sdata), .trig_pin(trig_pin),
    .dac_level(dac_level), .out_enable(out_enable),
    .spread_spectrum_enable(spread_spectrum_enable), .boost_output_level(boost_output_level),
    .power_state_msb(power_state_msb), .power_state_lsb(power_state_lsb),
    .boost_enable(boost_enable), .low_power(low_power));

  rffe_master_model #(.slave_id(sid)) m (.clock(clock), .sclk(sclk), .sdata(sdata));

  // ----------------------------------------------------------------
  // expected values
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [4:0] dac_addr(input int i);
    return 5'((i < 3) ? i + 2 : i + 3);
  endfunction

  function automatic logic [5:0] exp_oe(input logic [6:0] k, input logic [1:0] p);
    return {k[4], k[5], k[0], k[1], k[2], k[3]} & {6{p == 2'h0}};
  endfunction

  task automatic rnd();
    lfsr_r = lfsr(lfsr_r);
  endtask

  task automatic apply(input logic [4:0] a, input logic [7:0] d);
    int i;
    i = (a < 5'h05) ? int'(a) - 2 : int'(a) - 3;
    case (a)
      `OFS_OUTPUT_ENABLE_MASK: oe_x = d[6:0];
      `OFS_LAST_DAC_SELECT: last_x = d[2:0];
      `OFS_BOOST: boost_x = d | 8'h10;
      `OFS_TRIG_CFG: cfg_x = d & 8'h13;
      `OFS_PM_TRIG:
      begin
        if (d[2:0] != 3'h0) act_x = sh_x;
        msk_x = d[5:3];
        if (d[7:6] != 2'h3) pm_x = d[7:6];
      end
      `OFS_DAC_A, `OFS_DAC_B, `OFS_DAC_C, `OFS_DAC_D, `OFS_DAC_E, `OFS_DAC_F:
      begin
        sh_x[i] = d;
        if (cfg_x[4] && msk_x[0] && i == 2) act_x[2:0] = sh_x[2:0];
        if (cfg_x[4] && msk_x[1] && i == 5) act_x[5:3] = sh_x[5:3];
        if (cfg_x[4] && msk_x[2] && last_x == i + 1) act_x = sh_x;
      end
      default: ;
    endcase
  endtask

  // ----------------------------------------------------------------
  // drivers and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    m.reg_write(a, d);
    apply(a, d);
  endtask

  task automatic pin(input logic lv);
    if (lv == cfg_x[1] && !cfg_x[4] && !cfg_x[0]) act_x = sh_x;
    @(posedge clock) trig_pin <= lv;
  endtask

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_all();
    repeat (6) @(posedge clock);
    @(negedge clock);
    check("dac_level", dac_level, act_x);
    check("out_enable", 48'(out_enable), 48'(exp_oe(oe_x, pm_x)));
    check("spread", 48'(spread_spectrum_enable), 48'(oe_x[6]));
    check("boost", 48'(boost_output_level), 48'(boost_x));
    check("power", 48'(pw_seen), 48'({pm_x, !pm_x[1], pm_x == 2'h2}));
  endtask

  task automatic fill();
    for (int i = 0; i < 6; i++)
    begin
      rnd();
      if (i == 0) wr(dac_addr(0), ~lfsr_r);
      wr(dac_addr(i), lfsr_r);
      check_all();
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    check_all();
    m.reg0_write(7'h2A);
    apply(`OFS_OUTPUT_ENABLE_MASK, 8'h2A);
    check_all();
    wr(`OFS_OUTPUT_ENABLE_MASK, 8'h55);
    check_all();
    m.ext_write(`OFS_OUTPUT_ENABLE_MASK, 8'h7F, 8'h11);
    apply(`OFS_OUTPUT_ENABLE_MASK, 8'h7F);
    check_all();
    for (int k = 0; k < 3; k++)
    begin
      fill();
      wr(`OFS_PM_TRIG, 8'(8'h01 << k));
      check_all();
      fill();
    end
    for (int k = 0; k < 4; k++)
    begin
      rnd();
      wr(`OFS_LAST_DAC_SELECT, 8'(1 + lfsr_r % 6));
      wr(`OFS_PM_TRIG, 8'((k < 3) ? 8'h08 << k : 8'h00));
      fill();
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_TRIG_CFG, pcfg[k]);
      fill();
      pin(1'b1);
      check_all();
      pin(1'b0);
      check_all();
      fill();
      wr(`OFS_PM_TRIG, 8'h04);
      check_all();
    end
    for (int k = 1; k < 5; k++)
    begin
      wr(`OFS_PM_TRIG, 8'(k << 6));
      check_all();
    end
    wr(`OFS_BOOST, 8'h00);
    check_all();
    wr(`OFS_BOOST, 8'hE5);
    check_all();
    m.bad_par = 1'b1;
    m.reg_write(`OFS_BOOST, 8'h03);
    check_all();
    for (int n = 0; n < 30; n++)
    begin
      rnd();
      v = lfsr_r;
      m.half = 2 + v[1:0];
      rnd();
      if (v[4:2] < 3'h6) wr(dac_addr(v[4:2]), lfsr_r);
      else wr(v[2] ? `OFS_PM_TRIG : `OFS_TRIG_CFG, lfsr_r);
      if (v[5]) pin(~trig_pin);
      check_all();
    end
    tally_and_finish();
  end
endmodule
